// file: pts_host_ctrl.sv
`timescale 1ns/1ps
module pts_host_ctrl
    import pts_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic [7:0]  switch_in,
    pts_link_if.host         link
);
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] baud_port;
    logic       busy_d;
    logic       ack;
    pts_cmd_t   cmd;
    logic       cmd_valid;
    logic [7:0] cmd_data;

    wire wr_en  = psel && penable && pwrite;
    wire busy   = link.sw_buffer[PTS_BUSY_BIT];
    wire done_ev = busy_d && !busy;
    wire xfer_ev = !link.diag_write_strobe_n;
    wire hit_ctrl = paddr == PTS_CTRL_OFS;
    wire hit_prog = paddr == PTS_PROG_OFS;
    wire hit_stat = paddr == PTS_IRQ_STAT_OFS;
    wire hit_mask = paddr == PTS_IRQ_MASK_OFS;
    wire mapped = hit_ctrl || hit_prog || hit_stat || hit_mask
               || paddr == PTS_STATUS_OFS || paddr == PTS_DATA_OFS
               || paddr == PTS_SWITCH_OFS || paddr == PTS_BAUD_OFS;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq     = |(irq_stat & irq_mask);

    always_comb begin
        unique case (paddr)
            PTS_STATUS_OFS:   prdata = {31'h0, busy};
            PTS_DATA_OFS:     prdata = {24'h0, link.data_out};
            PTS_IRQ_STAT_OFS: prdata = {30'h0, irq_stat};
            PTS_IRQ_MASK_OFS: prdata = {30'h0, irq_mask};
            PTS_SWITCH_OFS:   prdata = {24'h0, link.sw_buffer};
            PTS_BAUD_OFS:     prdata = {24'h0, baud_port & PTS_BAUD_MASK};
            default:          prdata = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd       <= PTS_CMD_NONE;
            cmd_valid <= 1'b0;
            cmd_data  <= PTS_RESET_BYTE;
        end else begin
            cmd_valid <= wr_en && (hit_prog
                      || (hit_ctrl && pwdata[PTS_CTRL_EXEC_BIT]));
            cmd       <= hit_prog ? PTS_CMD_LOAD : PTS_CMD_EXEC;
            cmd_data  <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat  <= 2'b00;
            irq_mask  <= 2'b00;
            busy_d    <= 1'b0;
            ack       <= 1'b0;
            baud_port <= PTS_RESET_BYTE;
        end else begin
            busy_d <= busy;
            ack    <= !link.bus_request_n;
            // set wins over write-one-to-clear
            irq_stat <= (irq_stat & ~((wr_en && hit_stat) ? pwdata[1:0]
                                                          : 2'b00))
                      | {xfer_ev, done_ev};
            if (wr_en && hit_mask) begin
                irq_mask <= pwdata[1:0];
            end
            if (xfer_ev) begin
                baud_port <= link.bus_data_from_seq & PTS_BAUD_MASK;
            end
        end
    end

    assign link.cmd             = cmd;
    assign link.cmd_valid       = cmd_valid;
    assign link.cmd_data        = cmd_data;
    assign link.bus_ack_n       = !ack;
    assign link.bus_data_to_seq = link.bus_read_strobe_n ? 8'h00 : switch_in;
endmodule // pts_host_ctrl

// file: pts_link_if.sv
`timescale 1ns/1ps
interface pts_link_if;
    import pts_pkg::*;
    pts_cmd_t   cmd;
    logic       cmd_valid;
    logic [7:0] cmd_data;
    logic [7:0] sw_buffer;
    logic [7:0] data_out;
    logic       bus_request_n;
    logic       bus_ack_n;
    logic       bus_read_strobe_n;
    logic       diag_write_strobe_n;
    logic [7:0] bus_data_to_seq;
    logic [7:0] bus_data_from_seq;
    modport device (
        input  cmd, cmd_valid, cmd_data, bus_ack_n, bus_data_to_seq,
        output sw_buffer, data_out, bus_request_n, bus_read_strobe_n,
        output diag_write_strobe_n, bus_data_from_seq
    );
    modport host (
        output cmd, cmd_valid, cmd_data, bus_ack_n, bus_data_to_seq,
        input  sw_buffer, data_out, bus_request_n, bus_read_strobe_n,
        input  diag_write_strobe_n, bus_data_from_seq
    );
endinterface // pts_link_if

// file: pts_link_sva.sv
`timescale 1ns/1ps
module pts_link_sva
    import pts_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire pts_cmd_t   cmd,
    input wire logic       cmd_valid,
    input wire logic [7:0] sw_buffer,
    input wire logic [7:0] data_out,
    input wire logic       bus_request_n,
    input wire logic       bus_ack_n,
    input wire logic       bus_read_strobe_n,
    input wire logic       diag_write_strobe_n,
    input wire logic [7:0] bus_data_to_seq,
    input wire logic [7:0] bus_data_from_seq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire busy = sw_buffer[PTS_BUSY_BIT];

    chk_exec_busy: assert property (
        cmd_valid && cmd == PTS_CMD_EXEC && !busy |=> busy)
        else $error("exec left busy low");
    chk_ack_after_req: assert property (
        $fell(bus_request_n) |-> ##[1:2] !bus_ack_n)
        else $error("no grant after request");
    chk_ack_needs_req: assert property (
        !bus_ack_n |-> !$past(bus_request_n))
        else $error("grant without request");
    chk_read_owned: assert property (
        !bus_read_strobe_n |-> !bus_request_n && !bus_ack_n)
        else $error("read strobe without bus");
    chk_read_pulse: assert property (
        !bus_read_strobe_n |=> bus_read_strobe_n)
        else $error("read strobe too long");
    chk_write_owned: assert property (
        !diag_write_strobe_n |-> !bus_request_n && !bus_ack_n)
        else $error("write strobe without bus");
    chk_write_pulse: assert property (
        !diag_write_strobe_n |=> diag_write_strobe_n)
        else $error("write strobe too long");
    chk_read_then_write: assert property (
        $rose(bus_read_strobe_n) |-> ##[0:2] !diag_write_strobe_n)
        else $error("no write after read");
    chk_baud_bits: assert property (
        (bus_data_from_seq & ~PTS_BAUD_MASK) == 8'h00)
        else $error("baud port holds stray bits");
    chk_idle_data: assert property (
        bus_read_strobe_n |-> bus_data_to_seq == 8'h00)
        else $error("source data outside read");
    chk_data_hold: assert property (
        !busy && !$past(busy) |-> $stable(data_out))
        else $error("data register moved while idle");
endmodule // pts_link_sva

// file: pts_loop_counter.sv
`timescale 1ns/1ps
module pts_loop_counter
    import pts_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       loop_ctrl_0,
    input  wire logic       loop_ctrl_1,
    input  wire logic [7:0] load_value,
    output logic            loop_terminal_n
);
    logic [7:0] count;
    logic [7:0] next_count;
    // ctrl_1 loads, ctrl_0 counts up
    assign next_count = loop_ctrl_1 ? load_value
                      : loop_ctrl_0 ? 8'(count + 8'h01) : count;
    assign loop_terminal_n = (count != PTS_LOOP_ALL_ONES);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= PTS_RESET_BYTE;
        end else begin
            count <= next_count;
        end
    end
endmodule // pts_loop_counter

// file: pts_pkg.sv
package pts_pkg;
    // host-side register map (APB, byte addresses)
    localparam logic [7:0] PTS_CTRL_OFS     = 8'h00;
    localparam logic [7:0] PTS_PROG_OFS     = 8'h04;
    localparam logic [7:0] PTS_STATUS_OFS   = 8'h08;
    localparam logic [7:0] PTS_DATA_OFS     = 8'h0C;
    localparam logic [7:0] PTS_IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] PTS_IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] PTS_SWITCH_OFS   = 8'h18;
    localparam logic [7:0] PTS_BAUD_OFS     = 8'h1C;
    // control register fields
    localparam int PTS_CTRL_EXEC_BIT = 0;
    localparam int PTS_CTRL_LOAD_BIT = 1;
    // switch buffer bit that shows execution in progress
    localparam int PTS_BUSY_BIT = 5;
    // baud port keeps data bits 3 and 4
    localparam logic [7:0] PTS_BAUD_MASK = 8'h18;
    // irq bits
    localparam int PTS_IRQ_DONE_BIT = 0;
    localparam int PTS_IRQ_XFER_BIT = 1;
    // opcodes
    localparam logic [7:0] PTS_OP_LOAD_DATA  = 8'h85;
    localparam logic [7:0] PTS_OP_JUMP_HALT  = 8'h04;
    localparam logic [7:0] PTS_OP_LOAD_LOOP  = 8'h81;
    localparam logic [7:0] PTS_OP_DEC_JNZ    = 8'h82;
    localparam logic [7:0] PTS_OP_JUMP       = 8'h83;
    localparam logic [7:0] PTS_OP_PORT_XFER  = 8'h84;
    localparam logic [7:0] PTS_LOOP_ALL_ONES = 8'hFF;
    localparam logic [7:0] PTS_RESET_BYTE   = 8'h00;
    // port command codes on the link
    typedef enum logic [1:0] {
        PTS_CMD_NONE,
        PTS_CMD_LOAD,
        PTS_CMD_EXEC,
        PTS_CMD_RDDATA
    } pts_cmd_t;
    localparam int PTS_PROG_DEPTH = 256;
endpackage

// file: pts_port_sequencer.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - host loads program, then executes it
// - busy bit high while running
// - opcode 85 loads output data register
// - opcode 04 jumps then halts
// - two-byte instructions, sequential program counter
// - loop counter counts up; load takes the operand unchanged
// - terminal output low at all ones
// - decrement-jump-not-zero branches until terminal
// - terminal routed through test multiplexer
// - host reads back data register
// - bus request waits for acknowledge
// - read strobe fetches source word
// - write strobe stores to destination
// - baud port keeps bits 3 and 4
// - port decoder selects load and execute
module pts_port_sequencer
    import pts_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    pts_link_if.device link
);
    typedef enum {
        PTS_IDLE, PTS_FETCH_OP, PTS_FETCH_ARG, PTS_EXEC,
        PTS_BUS_REQ, PTS_BUS_READ, PTS_BUS_WRITE, PTS_BUS_DONE
    } pts_state_t;

    pts_state_t state;
    pts_state_t next_state;
    logic [7:0] prog_mem [PTS_PROG_DEPTH];
    logic [7:0] load_addr;
    logic [7:0] pc;
    logic [7:0] next_pc;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] data_reg;
    logic [7:0] xfer_word;
    logic       busy;
    logic       next_busy;
    logic       loop_terminal_n;
    logic       test_cond;
    logic       loop_ctrl_0;
    logic       loop_ctrl_1;

    // opcode decode shared by the fetch and execute stages
    function automatic logic op_is(input logic [7:0] code,
                                   input logic [7:0] want);
        return (code == want);
    endfunction

    // port decode of host commands
    wire do_load = link.cmd_valid && (link.cmd == PTS_CMD_LOAD);
    wire do_exec = link.cmd_valid && (link.cmd == PTS_CMD_EXEC) && !busy;
    wire in_exec = (state == PTS_EXEC);
    wire op_loop = in_exec && op_is(opcode, PTS_OP_LOAD_LOOP);
    wire op_djnz = in_exec && op_is(opcode, PTS_OP_DEC_JNZ);
    wire op_data      = in_exec && op_is(opcode, PTS_OP_LOAD_DATA);
    wire st_fetch_op  = (state == PTS_FETCH_OP);
    wire st_fetch_arg = (state == PTS_FETCH_ARG);
    wire st_bus_read  = (state == PTS_BUS_READ);
    wire st_bus_write = (state == PTS_BUS_WRITE);
    wire owns_bus     = (state == PTS_BUS_REQ) || st_bus_read || st_bus_write;
    wire load_ok      = do_load && !busy;
    // loop counter steps while the dec-jnz operand is fetched
    wire step_loop    = st_fetch_arg && op_is(opcode, PTS_OP_DEC_JNZ);

    // test-condition multiplexer
    assign test_cond = op_djnz ? loop_terminal_n : 1'b0;
    assign loop_ctrl_1 = op_loop;
    assign loop_ctrl_0 = step_loop;

    pts_loop_counter u_loop (
        .pclk            (pclk),
        .presetn         (presetn),
        .loop_ctrl_0     (loop_ctrl_0),
        .loop_ctrl_1     (loop_ctrl_1),
        .load_value      (operand),
        .loop_terminal_n (loop_terminal_n)
    );

    // exec sees the counter after its step in the operand fetch
    always_comb begin
        next_state = state;
        next_pc    = pc;
        next_busy  = busy;
        unique case (state)
            PTS_IDLE: begin
                if (do_exec) begin
                    next_state = PTS_FETCH_OP;
                    next_pc    = PTS_RESET_BYTE;
                    next_busy  = 1'b1;
                end
            end
            PTS_FETCH_OP: begin
                next_state = PTS_FETCH_ARG;
                next_pc    = 8'(pc + 8'h01);
            end
            PTS_FETCH_ARG: begin
                next_state = PTS_EXEC;
                next_pc    = 8'(pc + 8'h01);
            end
            PTS_EXEC: begin
                next_state = PTS_FETCH_OP;
                unique case (opcode)
                    PTS_OP_JUMP_HALT: begin
                        next_pc    = operand;
                        next_state = PTS_IDLE;
                        next_busy  = 1'b0;
                    end
                    PTS_OP_JUMP: next_pc = operand;
                    PTS_OP_DEC_JNZ: begin
                        // terminal count reached: fall through
                        if (test_cond) begin
                            next_pc = operand;
                        end
                    end
                    PTS_OP_PORT_XFER: next_state = PTS_BUS_REQ;
                    default: next_state = PTS_FETCH_OP;
                endcase
            end
            PTS_BUS_REQ: begin
                if (!link.bus_ack_n) begin
                    next_state = PTS_BUS_READ;
                end
            end
            PTS_BUS_READ: next_state = PTS_BUS_WRITE;
            PTS_BUS_WRITE: next_state = PTS_BUS_DONE;
            PTS_BUS_DONE: begin
                if (link.bus_ack_n) begin
                    next_state = PTS_FETCH_OP;
                end
            end
            default: next_state = PTS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PTS_IDLE;
            pc    <= PTS_RESET_BYTE;
            busy  <= 1'b0;
        end else begin
            state <= next_state;
            pc    <= next_pc;
            busy  <= next_busy;
        end
    end

    // program memory load port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_addr <= PTS_RESET_BYTE;
        end else if (do_exec) begin
            load_addr <= PTS_RESET_BYTE;
        end else if (load_ok) begin
            load_addr <= 8'(load_addr + 8'h01);
        end
    end

    always_ff @(posedge pclk) begin
        if (load_ok) begin
            prog_mem[load_addr] <= link.cmd_data;
        end
    end

    // data path registers, one per stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opcode <= PTS_RESET_BYTE;
        end else if (st_fetch_op) begin
            opcode <= prog_mem[pc];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand <= PTS_RESET_BYTE;
        end else if (st_fetch_arg) begin
            operand <= prog_mem[pc];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg <= PTS_RESET_BYTE;
        end else if (op_data) begin
            data_reg <= operand;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_word <= PTS_RESET_BYTE;
        end else if (st_bus_read) begin
            xfer_word <= link.bus_data_to_seq & PTS_BAUD_MASK;
        end
    end

    // bus strobes follow the transfer states
    assign link.bus_request_n       = !owns_bus;
    assign link.bus_read_strobe_n   = !st_bus_read;
    assign link.diag_write_strobe_n = !st_bus_write;
    assign link.bus_data_from_seq   = xfer_word;
    assign link.data_out            = data_reg;
    assign link.sw_buffer = {2'b00, busy, 5'b00000};
endmodule // pts_port_sequencer

// file: test_port_transfer_sequencer.sv
`timescale 1ns/1ps
module test_port_transfer_sequencer import pts_pkg::*;;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  switch_in = 8'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  prog[$];
    int          n_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          n_rd = 0;
    int          n_wr = 0;

    always #10 pclk = ~pclk;
    pts_link_if link ();
    pts_host_ctrl pts_host_ctrl_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .switch_in(switch_in),
        .link(link.host));
    pts_port_sequencer pts_port_sequencer_i (.pclk(pclk),
        .presetn(presetn), .link(link.device));
    pts_link_sva pts_link_sva_i (.pclk(pclk), .presetn(presetn),
        .cmd(link.cmd), .cmd_valid(link.cmd_valid),
        .sw_buffer(link.sw_buffer), .data_out(link.data_out),
        .bus_request_n(link.bus_request_n), .bus_ack_n(link.bus_ack_n),
        .bus_read_strobe_n(link.bus_read_strobe_n),
        .diag_write_strobe_n(link.diag_write_strobe_n),
        .bus_data_to_seq(link.bus_data_to_seq),
        .bus_data_from_seq(link.bus_data_from_seq));

    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ins(input logic [7:0] op, input logic [7:0] arg);
        prog.push_back(op);
        prog.push_back(arg);
    endtask

    task automatic run();
        int i;
        foreach (prog[k]) xfer(1'b1, PTS_PROG_OFS, {24'h0, prog[k]});
        xfer(1'b1, PTS_CTRL_OFS, 32'h1);
        for (i = 0; i < 20 && link.sw_buffer[PTS_BUSY_BIT] !== 1'b1; i++)
            @(posedge pclk);
        cmp({31'h0, link.sw_buffer[PTS_BUSY_BIT]}, 32'h1);
        for (i = 0; i < 3000 && link.sw_buffer[PTS_BUSY_BIT] !== 1'b0; i++)
            @(posedge pclk);
        xfer(1'b0, PTS_SWITCH_OFS, 32'h0);
        cmp({31'h0, rd[PTS_BUSY_BIT]}, 32'h0);
        prog.delete();
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (link.bus_read_strobe_n === 1'b0) n_rd++;
        if (link.diag_write_strobe_n === 1'b0) n_wr++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        logic [7:0] sw;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, PTS_STATUS_OFS, 32'h0);
        cmp(rd, 32'h0);
        xfer(1'b0, PTS_IRQ_MASK_OFS, 32'h0);
        cmp(rd, 32'h0);
        // data register programs
        for (int k = 0; k < 2; k++) begin
            sw = k ? 8'hAA : 8'h55;
            ins(PTS_OP_LOAD_DATA, sw);
            ins(PTS_OP_JUMP_HALT, 8'h02);
            run();
            xfer(1'b0, PTS_DATA_OFS, 32'h0);
            cmp(rd, {24'h0, sw});
        end
        // loop counter program, six passes
        ins(PTS_OP_LOAD_LOOP, 8'hF9);
        for (int k = 0; k < 6; k++) begin
            ins(PTS_OP_DEC_JNZ, 8'(8 + 6 * k));
            ins(PTS_OP_LOAD_DATA, 8'(8'h11 * (k + 1)));
            ins(PTS_OP_JUMP, 8'h28);
        end
        ins(PTS_OP_LOAD_DATA, 8'hBB);
        ins(PTS_OP_JUMP_HALT, 8'h28);
        run();
        xfer(1'b0, PTS_DATA_OFS, 32'h0);
        cmp(rd, 32'h66);
        // port to port transfers
        for (int k = 0; k < 3; k++) begin
            sw = (k == 0) ? 8'hE7 : (k == 1) ? 8'h5A : 8'hD3;
            switch_in <= sw;
            n_rd = 0;
            n_wr = 0;
            ins(PTS_OP_PORT_XFER, 8'h00);
            ins(PTS_OP_JUMP_HALT, 8'h02);
            run();
            cmp(32'(n_rd), 32'h1);
            cmp(32'(n_wr), 32'h1);
            xfer(1'b0, PTS_BAUD_OFS, 32'h0);
            cmp(rd, {24'h0, sw & PTS_BAUD_MASK});
        end
        // interrupt status, mask and clear
        xfer(1'b0, PTS_IRQ_STAT_OFS, 32'h0);
        cmp(rd, 32'h3);
        cmp({31'h0, irq}, 32'h0);
        xfer(1'b1, PTS_IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        cmp({31'h0, irq}, 32'h1);
        xfer(1'b1, PTS_IRQ_STAT_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0);
        xfer(1'b0, PTS_IRQ_STAT_OFS, 32'h0);
        cmp(rd, 32'h2);
        // unmapped address
        xfer(1'b0, 8'h40, 32'h0);
        cmp({31'h0, er}, 32'h1);
        cmp(rd, 32'h0);
        conclude();
    end
endmodule // test_port_transfer_sequencer
